// ===== include/boce_pkg.sv
package boce_pkg;
	// ****************************************************************
	// bus map and widths
	// ****************************************************************
	localparam int APB_ADDR_W = 8;
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_WORK = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_COUNTER = 8'h0C;
	localparam logic [7:0] OFF_PAGE = 8'h10;
	localparam logic [7:0] OFF_STACK = 8'h14;
	localparam logic [7:0] OFF_WATCHDOG = 8'h18;
	localparam logic [7:0] OFF_FADDR = 8'h1C;
	localparam logic [7:0] OFF_FDATA = 8'h20;
	localparam int F_ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int PCNT_W = 13;
	localparam int K_W = 11;
	localparam int PAGE_W = 5;
	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int INS_OP_LSB = 0;
	localparam int INS_DEST_BIT = 3;
	localparam int INS_F_LSB = 4;
	localparam int INS_K_LSB = 16;
	localparam int PAGE_SEL_LSB = 3;
	localparam int ST_ZERO = 0;
	localparam int ST_DCARRY = 1;
	localparam int ST_CARRY = 2;
	localparam int ST_PDOWN = 3;
	localparam int ST_TOUT = 4;
	localparam int WD_PRE_LSB = 8;
	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [12:0] PCNT_RST = 13'h0000;
	localparam logic [4:0] PAGE_RST = 5'h00;
	localparam logic STATUS_BIT_RST = 1'h1;
	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		NO_OPERATION = 3'h0,
		WATCHDOG_CLEAR_OP = 3'h1,
		CALL_OP = 3'h2,
		COMPLEMENT_FILE_OP = 3'h3,
		CLEAR_FILE_OP = 3'h4,
		DECREMENT_FILE_OP = 3'h5,
		CLEAR_WORKING_OP = 3'h6,
		DECREMENT_SKIP_ZERO_OP = 3'h7
	} boce_op_t;
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_FETCH = 5'h02,
		S_EXEC = 5'h04,
		S_CALL2 = 5'h08,
		S_SKIP = 5'h10
	} boce_fsm_t;
endpackage

// ===== include/boce_mem_if.sv
`timescale 1ns/1ps
interface boce_mem_if;
	logic re;
	logic we;
	logic [boce_pkg::F_ADDR_W-1:0] addr;
	logic [boce_pkg::DATA_W-1:0] wdata;
	logic [boce_pkg::DATA_W-1:0] rdata;
	modport ctrl(output re, output we, output addr, output wdata,
		input rdata);
	modport mem(input re, input we, input addr, input wdata,
		output rdata);
endinterface

// ===== verilog/boce_fmem.sv
`timescale 1ns/1ps
module boce_fmem #(
	parameter int DEPTH = 2 ** boce_pkg::F_ADDR_W
) (
	input wire logic pclk,
	input wire logic presetn,
	boce_mem_if.mem mif
);
	// ****************************************************************
	// file register array
	// ****************************************************************
	logic [boce_pkg::DATA_W-1:0] mem_q [DEPTH];
	logic [boce_pkg::DATA_W-1:0] rdata_reg;

	// array has no reset, contents are undefined until written
	always_ff @(posedge pclk) begin
		if (mif.we) begin
			mem_q[mif.addr] <= mif.wdata;
		end
	end

	// read data registered, valid the cycle after re
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= boce_pkg::BYTE_RST;
		end else if (mif.re) begin
			rdata_reg <= mem_q[mif.addr];
		end
	end

	assign mif.rdata = rdata_reg;
endmodule

// ===== verilog/boce_alu.sv
`timescale 1ns/1ps
module boce_alu (
	input wire boce_pkg::boce_op_t op,
	input wire logic [boce_pkg::DATA_W-1:0] operand,
	output logic [boce_pkg::DATA_W-1:0] result,
	output logic zero
);
	// ****************************************************************
	// byte operations
	// ****************************************************************
	always_comb begin
		case (op)
			boce_pkg::COMPLEMENT_FILE_OP: begin
				result = ~operand;
			end
			boce_pkg::DECREMENT_FILE_OP,
			boce_pkg::DECREMENT_SKIP_ZERO_OP: begin
				result = operand - 8'h01;
			end
			default: begin
				result = 8'h00;
			end
		endcase
	end

	// zero test on the full eight-bit result
	assign zero = (result == 8'h00);
endmodule

// ===== verilog/boce_core.sv
// Functional notes
// - watchdog clear zeroes the watchdog count and its prescaler
// - watchdog clear sets timeout and power-down status bits; no operands
// - call pushes program counter plus one onto return stack top
// - call loads 11-bit target low, page latch bits 4:3 high
// - call accepts 0..2047, takes two cycles, flags unchanged
// - complement inverts file byte to work or file by dest bit, zero flag
// - clear file writes zero to file byte, sets zero flag
// - decrement file byte to work or file by dest bit, zero flag
// - clear working writes zero to work register, sets zero flag
// - decrement-skip steers result by dest bit, flags unchanged
// - zero result skips next instruction with a one-cycle no-op
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module boce_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [boce_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		boce_pkg::boce_fsm_t fsm;
		logic [31:0] instr;
		logic [7:0] work;
		logic zero_flag;
		logic digit_carry;
		logic carry;
		logic timeout_status_bit;
		logic power_down_status_bit;
		logic [12:0] program_counter;
		logic [4:0] program_page_latch;
		logic [12:0] return_stack_top;
		logic [7:0] watchdog_counter;
		logic [7:0] prescaler;
		logic [6:0] file_addr;
		logic rd_stage;
		logic ack;
		logic err;
		logic [31:0] rdata;
	} boce_state_t;

	boce_state_t s_reg;
	boce_state_t s_next;
	boce_mem_if mif();
	logic [7:0] alu_result;
	logic alu_zero;
	logic access;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic boce_pkg::boce_op_t op_of(input logic [31:0] ins);
		op_of = boce_pkg::boce_op_t'(ins[boce_pkg::INS_OP_LSB +: 3]);
	endfunction

	function automatic logic dest_of(input logic [31:0] ins);
		dest_of = ins[boce_pkg::INS_DEST_BIT];
	endfunction

	function automatic logic [6:0] f_of(input logic [31:0] ins);
		f_of = ins[boce_pkg::INS_F_LSB +: boce_pkg::F_ADDR_W];
	endfunction

	function automatic logic [10:0] k_of(input logic [31:0] ins);
		k_of = ins[boce_pkg::INS_K_LSB +: boce_pkg::K_W];
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		case (a)
			boce_pkg::OFF_INSTR, boce_pkg::OFF_WORK,
			boce_pkg::OFF_STATUS, boce_pkg::OFF_COUNTER,
			boce_pkg::OFF_PAGE, boce_pkg::OFF_STACK,
			boce_pkg::OFF_WATCHDOG, boce_pkg::OFF_FADDR,
			boce_pkg::OFF_FDATA: begin
				mapped = 1'h1;
			end
			default: begin
				mapped = 1'h0;
			end
		endcase
	endfunction

	// read mux; file data comes from the array read register
	function automatic logic [31:0] read_word(input logic [7:0] a,
		input boce_state_t s, input logic [7:0] fdata);
		logic [31:0] v;
		v = 32'h00000000;
		case (a)
			boce_pkg::OFF_INSTR: v = s.instr;
			boce_pkg::OFF_WORK: v[7:0] = s.work;
			boce_pkg::OFF_STATUS: begin
				v[boce_pkg::ST_ZERO] = s.zero_flag;
				v[boce_pkg::ST_DCARRY] = s.digit_carry;
				v[boce_pkg::ST_CARRY] = s.carry;
				v[boce_pkg::ST_PDOWN] = s.power_down_status_bit;
				v[boce_pkg::ST_TOUT] = s.timeout_status_bit;
			end
			boce_pkg::OFF_COUNTER: v[12:0] = s.program_counter;
			boce_pkg::OFF_PAGE: v[4:0] = s.program_page_latch;
			boce_pkg::OFF_STACK: v[12:0] = s.return_stack_top;
			boce_pkg::OFF_WATCHDOG: begin
				v[7:0] = s.watchdog_counter;
				v[boce_pkg::WD_PRE_LSB +: 8] = s.prescaler;
			end
			boce_pkg::OFF_FADDR: v[6:0] = s.file_addr;
			boce_pkg::OFF_FDATA: v[7:0] = fdata;
			default: v = 32'h00000000;
		endcase
		read_word = v;
	endfunction

	// ****************************************************************
	// submodules
	// ****************************************************************
	boce_fmem u_fmem (
		.pclk(pclk),
		.presetn(presetn),
		.mif(mif)
	);

	boce_alu u_alu (
		.op(op_of(s_reg.instr)),
		.operand(mif.rdata),
		.result(alu_result),
		.zero(alu_zero)
	);

	// ****************************************************************
	// next state
	// ****************************************************************
	// bus is served only while idle, so software never races execution
	assign access = psel && penable && !s_reg.ack;

	always_comb begin
		s_next = s_reg;
		s_next.ack = 1'h0;
		s_next.err = 1'h0;
		mif.re = 1'h0;
		mif.we = 1'h0;
		mif.addr = s_reg.file_addr;
		mif.wdata = pwdata[7:0];
		case (s_reg.fsm)
			boce_pkg::S_IDLE: begin
				if (access && !pwrite && paddr == boce_pkg::OFF_FDATA
					&& !s_reg.rd_stage) begin
					// first beat of a file read fetches the byte
					mif.re = 1'h1;
					s_next.rd_stage = 1'h1;
				end else if (access) begin
					s_next.rd_stage = 1'h0;
					s_next.ack = 1'h1;
					s_next.err = !mapped(paddr);
					s_next.rdata = pwrite ? 32'h00000000 :
						read_word(paddr, s_reg, mif.rdata);
				end
				// a write lands only at the edge where the master samples
				// pready high, so the transfer and its effect coincide
				if (psel && penable && pwrite && s_reg.ack) begin
					case (paddr)
						boce_pkg::OFF_INSTR: begin
							s_next.instr = pwdata;
							s_next.fsm = boce_pkg::S_FETCH;
						end
						boce_pkg::OFF_WORK: s_next.work = pwdata[7:0];
						boce_pkg::OFF_STATUS: begin
							s_next.zero_flag = pwdata[boce_pkg::ST_ZERO];
							s_next.digit_carry = pwdata[boce_pkg::ST_DCARRY];
							s_next.carry = pwdata[boce_pkg::ST_CARRY];
							s_next.power_down_status_bit =
								pwdata[boce_pkg::ST_PDOWN];
							s_next.timeout_status_bit =
								pwdata[boce_pkg::ST_TOUT];
						end
						boce_pkg::OFF_COUNTER:
							s_next.program_counter = pwdata[12:0];
						boce_pkg::OFF_PAGE:
							s_next.program_page_latch = pwdata[4:0];
						boce_pkg::OFF_WATCHDOG: begin
							s_next.watchdog_counter = pwdata[7:0];
							s_next.prescaler =
								pwdata[boce_pkg::WD_PRE_LSB +: 8];
						end
						boce_pkg::OFF_FADDR: s_next.file_addr = pwdata[6:0];
						boce_pkg::OFF_FDATA: mif.we = 1'h1;
						// stack top is read-only; unmapped has no effect
						default: mif.we = 1'h0;
					endcase
				end
			end
			boce_pkg::S_FETCH: begin
				// operand fetch; harmless for ops that ignore it
				mif.re = 1'h1;
				mif.addr = f_of(s_reg.instr);
				s_next.fsm = boce_pkg::S_EXEC;
			end
			boce_pkg::S_EXEC: begin
				s_next.fsm = boce_pkg::S_IDLE;
				s_next.program_counter = s_reg.program_counter + 13'h0001;
				mif.addr = f_of(s_reg.instr);
				mif.wdata = alu_result;
				case (op_of(s_reg.instr))
					boce_pkg::WATCHDOG_CLEAR_OP: begin
						s_next.watchdog_counter = boce_pkg::BYTE_RST;
						s_next.prescaler = boce_pkg::BYTE_RST;
						s_next.timeout_status_bit = 1'h1;
						s_next.power_down_status_bit = 1'h1;
					end
					boce_pkg::CALL_OP: begin
						// second cycle flushes the fetched word
						s_next.return_stack_top =
							s_reg.program_counter + 13'h0001;
						s_next.program_counter = {s_reg.program_page_latch[
							boce_pkg::PAGE_SEL_LSB +: 2],
							k_of(s_reg.instr)};
						s_next.fsm = boce_pkg::S_CALL2;
					end
					boce_pkg::COMPLEMENT_FILE_OP,
					boce_pkg::DECREMENT_FILE_OP: begin
						mif.we = dest_of(s_reg.instr);
						if (!dest_of(s_reg.instr)) begin
							s_next.work = alu_result;
						end
						s_next.zero_flag = alu_zero;
					end
					boce_pkg::CLEAR_FILE_OP: begin
						mif.we = 1'h1;
						mif.wdata = boce_pkg::BYTE_RST;
						s_next.zero_flag = 1'h1;
					end
					boce_pkg::CLEAR_WORKING_OP: begin
						s_next.work = boce_pkg::BYTE_RST;
						s_next.zero_flag = 1'h1;
					end
					boce_pkg::DECREMENT_SKIP_ZERO_OP: begin
						mif.we = dest_of(s_reg.instr);
						if (!dest_of(s_reg.instr)) begin
							s_next.work = alu_result;
						end
						if (alu_zero) begin
							// next word is dropped: step over it
							s_next.program_counter =
								s_reg.program_counter + 13'h0002;
							s_next.fsm = boce_pkg::S_SKIP;
						end
					end
					default: begin
						s_next.fsm = boce_pkg::S_IDLE;
					end
				endcase
			end
			boce_pkg::S_CALL2, boce_pkg::S_SKIP: begin
				s_next.fsm = boce_pkg::S_IDLE;
			end
			default: begin
				s_next.fsm = boce_pkg::S_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.fsm <= boce_pkg::S_IDLE;
			s_reg.program_counter <= boce_pkg::PCNT_RST;
			s_reg.program_page_latch <= boce_pkg::PAGE_RST;
			s_reg.timeout_status_bit <= boce_pkg::STATUS_BIT_RST;
			s_reg.power_down_status_bit <= boce_pkg::STATUS_BIT_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// bus outputs straight from the state flops
	assign prdata = s_reg.rdata;
	assign pready = s_reg.ack;
	assign pslverr = s_reg.err;

	// ****************************************************************
	// checks
	// ****************************************************************
	logic in_exec;
	boce_pkg::boce_op_t cur_op;
	assign in_exec = (s_reg.fsm == boce_pkg::S_EXEC);
	assign cur_op = op_of(s_reg.instr);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_wd_counter_zero: assert property (
		in_exec && cur_op == boce_pkg::WATCHDOG_CLEAR_OP
		|=> s_reg.watchdog_counter == 8'h00 && s_reg.prescaler == 8'h00)
		else $error("watchdog count or prescaler not cleared");
	a_wd_status_set: assert property (
		in_exec && cur_op == boce_pkg::WATCHDOG_CLEAR_OP
		|=> s_reg.timeout_status_bit && s_reg.power_down_status_bit)
		else $error("timeout or power-down bit not set");
	a_call_push: assert property (
		in_exec && cur_op == boce_pkg::CALL_OP
		|=> s_reg.return_stack_top == $past(s_reg.program_counter) + 13'h1)
		else $error("call return address wrong");
	a_call_target: assert property (
		in_exec && cur_op == boce_pkg::CALL_OP
		|=> s_reg.program_counter == {$past(s_reg.program_page_latch[4:3]),
		$past(k_of(s_reg.instr))})
		else $error("call target wrong");
	a_call_timing: assert property (
		in_exec && cur_op == boce_pkg::CALL_OP
		|=> s_reg.fsm == boce_pkg::S_CALL2 && $stable(s_reg.zero_flag)
		##1 s_reg.fsm == boce_pkg::S_IDLE)
		else $error("call not two cycles or flags moved");
	a_complement_file_op_value: assert property (
		in_exec && cur_op == boce_pkg::COMPLEMENT_FILE_OP
		|-> if (dest_of(s_reg.instr)) (mif.we && mif.wdata == ~mif.rdata)
		else (!mif.we ##1 s_reg.work == ~$past(mif.rdata)))
		else $error("complement result misplaced");
	a_clear_file_op_write: assert property (
		in_exec && cur_op == boce_pkg::CLEAR_FILE_OP
		|-> mif.we && mif.wdata == 8'h00 ##1 s_reg.zero_flag)
		else $error("clear file wrong");
	a_decrement_file_op_value: assert property (
		in_exec && cur_op == boce_pkg::DECREMENT_FILE_OP
		&& !dest_of(s_reg.instr)
		|=> s_reg.work == $past(mif.rdata) - 8'h01)
		else $error("decrement to work wrong");
	a_clear_working_op_zero: assert property (
		in_exec && cur_op == boce_pkg::CLEAR_WORKING_OP
		|=> s_reg.work == 8'h00 && s_reg.zero_flag)
		else $error("clear working wrong");
	a_dskip_flags: assert property (
		in_exec && cur_op == boce_pkg::DECREMENT_SKIP_ZERO_OP
		|=> $stable(s_reg.zero_flag) && $stable(s_reg.carry)
		&& $stable(s_reg.digit_carry))
		else $error("decrement-skip touched flags");
	a_dskip_skip: assert property (
		in_exec && cur_op == boce_pkg::DECREMENT_SKIP_ZERO_OP
		&& mif.rdata == 8'h01
		|=> s_reg.fsm == boce_pkg::S_SKIP
		&& s_reg.program_counter == $past(s_reg.program_counter) + 13'h2
		##1 s_reg.fsm == boce_pkg::S_IDLE)
		else $error("zero result did not skip");
	a_zero_flag: assert property (
		in_exec && (cur_op == boce_pkg::COMPLEMENT_FILE_OP
		|| cur_op == boce_pkg::DECREMENT_FILE_OP)
		|=> (s_reg.zero_flag == ($past(mif.rdata) ==
		(($past(cur_op) == boce_pkg::COMPLEMENT_FILE_OP) ? 8'hFF : 8'h01)))
		&& $stable(s_reg.carry) && $stable(s_reg.digit_carry))
		else $error("zero flag wrong after byte op");

	c_call: cover property (in_exec && cur_op == boce_pkg::CALL_OP);
	c_skip: cover property (s_reg.fsm == boce_pkg::S_SKIP);
	c_wdclr: cover property (in_exec
		&& cur_op == boce_pkg::WATCHDOG_CLEAR_OP);
	c_fread: cover property (s_reg.ack && s_reg.rd_stage == 1'h0
		&& $past(s_reg.rd_stage));
endmodule

// ===== bench/boce_core_tb_top.sv
`timescale 1ns/1ps
module boce_core_tb_top;
	// ****************************************************************
	// clock, reset and bus signals
	// ****************************************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] rd;
	logic err;
	int fail_count = 0;
	int compares = 0;

	// free-running 100 MHz clock
	always #5 pclk = ~pclk;

	boce_core i_boce_core (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);

	// ****************************************************************
	// reporting
	// ****************************************************************
	task automatic test_done();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ****************************************************************
	// bus tasks
	// ****************************************************************
	// one transfer; the slave may stretch it while an instruction runs,
	// so the wait is bounded rather than a fixed number of cycles
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fail_count++;
			$display("[FAIL] pready expected 1 seen %b", pready);
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// instruction word: op low, dest, file address, call target high
	task automatic exec(input boce_pkg::boce_op_t op, input logic d,
		input logic [6:0] f, input logic [10:0] k);
		logic [31:0] w;
		w = 32'h00000000;
		w[2:0] = op;
		w[boce_pkg::INS_DEST_BIT] = d;
		w[10:4] = f;
		w[26:16] = k;
		apb(1'b1, boce_pkg::OFF_INSTR, w);
	endtask

	// presets work, status, counter and one file byte, runs one op,
	// then reads every place the op may have touched
	task automatic byte_case(input string nm, input boce_pkg::boce_op_t op,
		input logic d, input logic [6:0] f, input logic [7:0] fin,
		input logic [7:0] st_in, input logic [7:0] w_exp,
		input logic [7:0] f_exp, input logic [7:0] st_exp,
		input logic [12:0] pc_exp);
		apb(1'b1, boce_pkg::OFF_STATUS, {24'h000000, st_in});
		apb(1'b1, boce_pkg::OFF_WORK, 32'h000000EE);
		apb(1'b1, boce_pkg::OFF_COUNTER, 32'h00000100);
		apb(1'b1, boce_pkg::OFF_FADDR, {25'h0000000, f});
		apb(1'b1, boce_pkg::OFF_FDATA, {24'h000000, fin});
		exec(op, d, f, 11'h000);
		apb(1'b0, boce_pkg::OFF_WORK, 32'h00000000);
		chk({nm, " work"}, {24'h000000, w_exp}, rd);
		apb(1'b1, boce_pkg::OFF_FADDR, {25'h0000000, f});
		apb(1'b0, boce_pkg::OFF_FDATA, 32'h00000000);
		chk({nm, " file"}, {24'h000000, f_exp}, rd);
		apb(1'b0, boce_pkg::OFF_STATUS, 32'h00000000);
		chk({nm, " status"}, {24'h000000, st_exp}, rd);
		apb(1'b0, boce_pkg::OFF_COUNTER, 32'h00000000);
		chk({nm, " counter"}, {19'h00000, pc_exp}, rd);
		$display("test %s done", nm);
	endtask

	// call with a page latch whose other bits must not leak into the pc
	task automatic call_case(input logic [4:0] page, input logic [12:0] pc,
		input logic [10:0] k, input logic [12:0] stk_exp,
		input logic [12:0] pc_exp);
		apb(1'b1, boce_pkg::OFF_PAGE, {27'h0000000, page});
		apb(1'b1, boce_pkg::OFF_COUNTER, {19'h00000, pc});
		apb(1'b1, boce_pkg::OFF_STATUS, 32'h00000007);
		exec(boce_pkg::CALL_OP, 1'b0, 7'h00, k);
		apb(1'b1, boce_pkg::OFF_STACK, 32'h00000555);
		chk("stack write error", 32'h00000000, {31'h00000000, err});
		apb(1'b0, boce_pkg::OFF_STACK, 32'h00000000);
		chk("call stack", {19'h00000, stk_exp}, rd);
		apb(1'b0, boce_pkg::OFF_COUNTER, 32'h00000000);
		chk("call counter", {19'h00000, pc_exp}, rd);
		apb(1'b0, boce_pkg::OFF_STATUS, 32'h00000000);
		chk("call status", 32'h00000007, rd);
		$display("test call done");
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// state after reset
		apb(1'b0, boce_pkg::OFF_STATUS, 32'h00000000);
		chk("reset status", 32'h00000018, rd);
		apb(1'b0, boce_pkg::OFF_WATCHDOG, 32'h00000000);
		chk("reset watchdog", 32'h00000000, rd);
		apb(1'b0, 8'h40, 32'h00000000);
		chk("unmapped error", 32'h00000001, {31'h00000000, err});
		chk("unmapped data", 32'h00000000, rd);
		$display("test reset done");
		// watchdog clear from a dirty count, prescaler and status
		apb(1'b1, boce_pkg::OFF_WATCHDOG, 32'h0000A5C3);
		apb(1'b1, boce_pkg::OFF_STATUS, 32'h00000007);
		exec(boce_pkg::WATCHDOG_CLEAR_OP, 1'b0, 7'h00, 11'h000);
		apb(1'b0, boce_pkg::OFF_WATCHDOG, 32'h00000000);
		chk("wd count and prescaler", 32'h00000000, rd);
		apb(1'b0, boce_pkg::OFF_STATUS, 32'h00000000);
		chk("wd status", 32'h0000001F, rd);
		$display("test watchdog done");
		// call at both ends of the target range
		call_case(5'h18, 13'h0123, 11'h7FF, 13'h0124, 13'h1FFF);
		call_case(5'h0F, 13'h1ABC, 11'h000, 13'h1ABD, 13'h0800);
		// byte operations; carries preset, except in the two clears and dskip nz, to catch stray flag writes
		byte_case("complement_file_op w", boce_pkg::COMPLEMENT_FILE_OP, 1'b0, 7'h7F,
			8'h5A, 8'h06, 8'hA5, 8'h5A, 8'h06, 13'h0101);
		byte_case("complement_file_op f", boce_pkg::COMPLEMENT_FILE_OP, 1'b1, 7'h7F,
			8'hFF, 8'h06, 8'hEE, 8'h00, 8'h07, 13'h0101);
		byte_case("clear_file_op", boce_pkg::CLEAR_FILE_OP, 1'b1, 7'h00,
			8'h33, 8'h00, 8'hEE, 8'h00, 8'h01, 13'h0101);
		byte_case("decrement_file_op w", boce_pkg::DECREMENT_FILE_OP, 1'b0, 7'h05,
			8'h01, 8'h06, 8'h00, 8'h01, 8'h07, 13'h0101);
		byte_case("decrement_file_op f", boce_pkg::DECREMENT_FILE_OP, 1'b1, 7'h05,
			8'h00, 8'h07, 8'hEE, 8'hFF, 8'h06, 13'h0101);
		byte_case("clear_working_op", boce_pkg::CLEAR_WORKING_OP, 1'b0, 7'h05,
			8'h44, 8'h18, 8'h00, 8'h44, 8'h19, 13'h0101);
		byte_case("dskip nz", boce_pkg::DECREMENT_SKIP_ZERO_OP, 1'b1, 7'h03,
			8'h02, 8'h00, 8'hEE, 8'h01, 8'h00, 13'h0101);
		byte_case("dskip z w", boce_pkg::DECREMENT_SKIP_ZERO_OP, 1'b0, 7'h03,
			8'h01, 8'h06, 8'h00, 8'h01, 8'h06, 13'h0102);
		byte_case("dskip z f", boce_pkg::DECREMENT_SKIP_ZERO_OP, 1'b1, 7'h7F,
			8'h01, 8'h1E, 8'hEE, 8'h00, 8'h1E, 13'h0102);
		byte_case("nop", boce_pkg::NO_OPERATION, 1'b1, 7'h03,
			8'h09, 8'h05, 8'hEE, 8'h09, 8'h05, 13'h0101);
		test_done();
	end
endmodule
